// ---- spdc_core.sv ----
// Serial-programmed PLL divider core: serial loader, dividers, phase comparator
`timescale 1ns/100ps
`default_nettype none
module spdc_core #(
  parameter int unsigned LOCK_TOL = spdc_pkg::LOCK_TOL_CYC
) (
  // Clock and control
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic ce_i,
  // Serial programming link
  input  wire logic ser_clk_i,
  input  wire logic ser_data_i,
  input  wire logic load_strobe_i,
  // Frequency inputs
  input  wire logic osc_i,
  input  wire logic vco_i,
  // Monitors and lock
  output logic      ref_divider_monitor_o,
  output logic      main_divider_monitor_o,
  output logic      lock_indicator_o,
  // Passive filter pump (three-state)
  output logic      pump_pas_o,
  output logic      pump_pas_oe_o,
  // Active filter pump (three-state)
  output logic      pump_act_o,
  output logic      pump_act_oe_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0]                   sclk_sy;
    logic [1:0]                   sdat_sy;
    logic [1:0]                   le_sy;
    logic [2:0]                   osc_sy;
    logic [2:0]                   vco_sy;
    logic [spdc_pkg::SHIFT_W-1:0] shreg;
    logic [spdc_pkg::REF_W-1:0]   ref_lat;
    logic [spdc_pkg::MAIN_W-1:0]  main_lat;
    logic [spdc_pkg::PRE_W-1:0]   pre_cnt;
    logic                         pre_pulse;
    logic                         ref_mon;
    logic                         main_mon;
    logic                         up;
    logic                         dn;
    logic [3:0]                   err_cnt;
    logic                         lock;
  } spdc_st_t;

  spdc_st_t st_ff;
  spdc_st_t nxt_st;
  logic     ref_pulse;
  logic     main_pulse;

  function automatic logic rise(input logic [2:0] s);
    rise = s[1] & ~s[2];
  endfunction : rise

  // ****************************************
  // Dividers
  // ****************************************
  spdc_divider #(.W(spdc_pkg::REF_W)) u_ref_div (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .tick_i    (rise(st_ff.osc_sy)),
    .factor_i  (st_ff.ref_lat),
    .pulse_o   (ref_pulse)
  );

  spdc_divider #(.W(spdc_pkg::MAIN_W)) u_main_div (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .tick_i    (st_ff.pre_pulse),
    .factor_i  (st_ff.main_lat),
    .pulse_o   (main_pulse)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st         = st_ff;
    // Stage 0 is only read by stage 1
    nxt_st.sclk_sy = {st_ff.sclk_sy[1:0], ser_clk_i};
    nxt_st.sdat_sy = {st_ff.sdat_sy[0], ser_data_i};
    nxt_st.le_sy   = {st_ff.le_sy[0], load_strobe_i};
    nxt_st.osc_sy  = {st_ff.osc_sy[1:0], osc_i};
    nxt_st.vco_sy  = {st_ff.vco_sy[1:0], vco_i};

    // Data is taken from stage 1, the same synchronizer stage at which the clock edge is seen
    if (rise(st_ff.sclk_sy)) begin
      nxt_st.shreg = {st_ff.shreg[spdc_pkg::SHIFT_W-2:0], st_ff.sdat_sy[1]};
    end

    // Latches track the shift register while the strobe stays high
    if (st_ff.le_sy[1]) begin
      if (st_ff.shreg[0]) begin
        nxt_st.ref_lat = st_ff.shreg[spdc_pkg::REF_W:1];
      end else begin
        nxt_st.main_lat = st_ff.shreg[spdc_pkg::MAIN_W:1];
      end
    end

    // Fixed 64 modulus; the swallow option is unused without a swallow counter
    nxt_st.pre_pulse = 1'b0;
    if (rise(st_ff.vco_sy)) begin
      if (st_ff.pre_cnt == spdc_pkg::PRE_W'(spdc_pkg::PRE_LO - 1)) begin
        nxt_st.pre_cnt   = '0;
        nxt_st.pre_pulse = 1'b1;
      end else begin
        nxt_st.pre_cnt = st_ff.pre_cnt + spdc_pkg::PRE_W'(1);
      end
    end

    // Divided outputs held high for one cycle per edge
    nxt_st.ref_mon  = ref_pulse;
    nxt_st.main_mon = main_pulse;

    // Tri-state phase/frequency detector
    if (ref_pulse && main_pulse) begin
      nxt_st.up = 1'b0;
      nxt_st.dn = 1'b0;
    end else if (ref_pulse) begin
      nxt_st.up = ~st_ff.dn;
      nxt_st.dn = 1'b0;
    end else if (main_pulse) begin
      nxt_st.dn = ~st_ff.up;
      nxt_st.up = 1'b0;
    end

    // Lock: low while the error window is wider than tolerance
    if (st_ff.up || st_ff.dn) begin
      if (st_ff.err_cnt != 4'hf) begin
        nxt_st.err_cnt = st_ff.err_cnt + 4'h1;
      end
    end else begin
      nxt_st.err_cnt = 4'h0;
    end
    nxt_st.lock = ~((st_ff.up || st_ff.dn) && (st_ff.err_cnt >= 4'(LOCK_TOL)));
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_ff          <= '0;
      st_ff.ref_lat  <= spdc_pkg::REF_RST;
      st_ff.main_lat <= spdc_pkg::MAIN_RST;
      st_ff.lock     <= 1'b1;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ref_divider_monitor_o  = st_ff.ref_mon;
  assign main_divider_monitor_o = st_ff.main_mon;
  assign lock_indicator_o       = st_ff.lock;
  assign pump_pas_o             = st_ff.up;
  assign pump_pas_oe_o          = st_ff.up | st_ff.dn;
  assign pump_act_o             = st_ff.dn;
  assign pump_act_oe_o          = st_ff.up | st_ff.dn;

  // ****************************************
  // Checks
  // ****************************************
  property p_shift;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && rise(st_ff.sclk_sy)) |=> st_ff.shreg[0] == $past(st_ff.sdat_sy[1]);
  endproperty
  a_shift: assert property (p_shift) else $error("Shift missed bit");

  property p_ref_load;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && st_ff.le_sy[1] && st_ff.shreg[0]) |=> st_ff.ref_lat == $past(st_ff.shreg[16:1]);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("Reference latch not loaded");

  property p_main_load;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      (ce_i && st_ff.le_sy[1] && !st_ff.shreg[0])
        |=> st_ff.main_lat == $past(st_ff.shreg[10:1]) && $stable(st_ff.ref_lat);
  endproperty
  a_main_load: assert property (p_main_load) else $error("Main latch load wrong");

  property p_hold;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !st_ff.le_sy[1] |=> $stable(st_ff.ref_lat) && $stable(st_ff.main_lat);
  endproperty
  a_hold: assert property (p_hold) else $error("Latch changed without strobe");

  property p_pre;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      st_ff.pre_pulse |-> $past(st_ff.pre_cnt) == 7'h3f;
  endproperty
  a_pre: assert property (p_pre) else $error("Prescaler modulus wrong");

  property p_mon;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      ce_i && ref_pulse |=> ref_divider_monitor_o;
  endproperty
  a_mon: assert property (p_mon) else $error("Reference monitor missed");

  property p_mmon;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      ce_i && main_pulse |=> main_divider_monitor_o;
  endproperty
  a_mmon: assert property (p_mmon) else $error("Main monitor missed");

  property p_pump;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      pump_pas_oe_o |-> pump_act_o == !pump_pas_o && pump_act_oe_o;
  endproperty
  a_pump: assert property (p_pump) else $error("Pump polarity wrong");

  property p_float;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
      !(st_ff.up || st_ff.dn) |-> !pump_pas_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("Pump not floating");
endmodule : spdc_core
`default_nettype wire

// ---- spdc_pkg.sv ----
// Constants for the serial-programmed PLL divider core
package spdc_pkg;
  localparam int unsigned REF_W        = 16;
  localparam int unsigned MAIN_W       = 10;
  localparam int unsigned SHIFT_W      = 17;
  localparam int unsigned PRE_LO       = 64;
  localparam int unsigned PRE_W        = 7;
  localparam logic [15:0] REF_RST      = 16'h0005;
  localparam logic [9:0]  MAIN_RST     = 10'h005;
  localparam int unsigned LOCK_TOL_CYC = 2;
endpackage : spdc_pkg

// ---- spdc_divider.sv ----
// Programmable counter that emits a one-cycle pulse every factor input events
`timescale 1ns/100ps
`default_nettype none
module spdc_divider #(
  parameter int unsigned W = 16
) (
  // Clock and control
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic         ce_i,
  // Count events
  input  wire logic         tick_i,
  input  wire logic [W-1:0] factor_i,
  // Output
  output logic              pulse_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } spdc_div_st_t;

  spdc_div_st_t st_ff;
  spdc_div_st_t nxt_st;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.pulse = 1'b0;
    if (tick_i) begin
      // Reload picks up a newly latched factor only at terminal count
      if (st_ff.cnt <= W'(1)) begin
        nxt_st.cnt   = factor_i;
        nxt_st.pulse = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign pulse_o = st_ff.pulse;
endmodule : spdc_divider
`default_nettype wire

// ---- spdc_host.sv ----
// Host model that loads divide factors over the serial link
`timescale 1ns/100ps
`default_nettype none
module spdc_host (
  // Serial link
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic load_strobe_o
);
  initial begin
    ser_clk_o     = 1'b0;
    ser_data_o    = 1'b0;
    load_strobe_o = 1'b0;
  end
  // ****************************
  // Word transfer
  // ****************************
  // Timed by delays of whole system clock periods, so its edges stay 3 ns after the calling clock edge
  task automatic send(input logic [16:0] word, input int nbits, input logic strobe);
    #3;
    for (int i = nbits - 1; i >= 0; i--) begin
      ser_data_o = word[i];
      #80 ser_clk_o = 1'b1;
      #80 ser_clk_o = 1'b0;
    end
    // Clock idles low; data must not keep showing the last bit
    ser_data_o = ~ser_data_o;
    #160 load_strobe_o = strobe;
    #160 load_strobe_o = 1'b0;
    #160;
  endtask : send
endmodule : spdc_host
`default_nettype wire

// ---- spdc_core_test.sv ----
// Self-checking testbench for the serial-programmed divider core
`timescale 1ns/100ps
`default_nettype none
module spdc_core_test;
  localparam int LIM = 8000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic osc = 1'b0;
  logic vco = 1'b0;
  logic ser_clk, ser_data, load;
  logic ref_mon, main_mon, lock, pas, pas_oe, act, act_oe;
  int   miscompares = 0;
  int   comparisons = 0;
  int   ph = 0;
  always #10 clk = ~clk;
  // Both sources run at a sixth of the system clock
  always @(negedge clk) begin
    ph = (ph == 2) ? 0 : ph + 1;
    if (ph == 0) begin
      osc <= ~osc;
      vco <= ~vco;
    end
  end
  spdc_core u_spdc_core (
    .clk_sys_i(clk), .sys_rst_i(rst), .ce_i(1'b1),
    .ser_clk_i(ser_clk), .ser_data_i(ser_data), .load_strobe_i(load),
    .osc_i(osc), .vco_i(vco),
    .ref_divider_monitor_o(ref_mon), .main_divider_monitor_o(main_mon), .lock_indicator_o(lock),
    .pump_pas_o(pas), .pump_pas_oe_o(pas_oe), .pump_act_o(act), .pump_act_oe_o(act_oe)
  );
  spdc_host u_spdc_host (.ser_clk_o(ser_clk), .ser_data_o(ser_data), .load_strobe_o(load));
  // ****************************
  // Helpers
  // ****************************
  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task automatic wait_pulse(input logic sel, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((sel ? main_mon : ref_mon) !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      check(1'b0, "monitor pulse timeout");
      end_of_test;
    end
  endtask : wait_pulse
  // First interval after a load may still use the old factor
  task automatic period(input logic sel, input int exp);
    int n;
    repeat (3) wait_pulse(sel, n);
    check(n == exp, "divider period");
  endtask : period
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_ref;
    logic [15:0] f[3] = '{16'h0005, 16'h0007, 16'h0100};
    foreach (f[i]) begin
      u_spdc_host.send({f[i], 1'b1}, 17, 1'b1);
      period(1'b0, 6 * int'(f[i]));
    end
  endtask : t_ref
  task automatic t_main;
    u_spdc_host.send({6'h00, 10'h006, 1'b0}, 11, 1'b1);
    period(1'b1, int'(spdc_pkg::PRE_LO) * 6 * 6);
    period(1'b0, 6 * 256);
  endtask : t_main
  task automatic t_hold;
    u_spdc_host.send({16'h0009, 1'b1}, 17, 1'b0);
    period(1'b0, 6 * 256);
  endtask : t_hold
  task automatic t_pump;
    int   n;
    logic lo;
    u_spdc_host.send({16'h0005, 1'b1}, 17, 1'b1);
    repeat (2) wait_pulse(1'b0, n);
    repeat (2) @(negedge clk);
    check(pas_oe === 1'b1 && pas === 1'b1, "passive pump, reference leads");
    check(act_oe === 1'b1 && act === 1'b0, "active pump, reference leads");
    lo = 1'b0;
    repeat (2500) begin
      @(negedge clk);
      if (lock === 1'b0) lo = 1'b1;
    end
    check(lo, "lock stayed high while unlocked");
  endtask : t_pump
  task automatic t_vco;
    int n;
    u_spdc_host.send({16'h03e8, 1'b1}, 17, 1'b1);
    // Sync to the reload pulse so no reference pulse falls between the two main divider pulses
    wait_pulse(1'b0, n);
    repeat (2) wait_pulse(1'b1, n);
    repeat (2) @(negedge clk);
    check(pas_oe === 1'b1 && pas === 1'b0, "passive pump, vco leads");
    check(act_oe === 1'b1 && act === 1'b1, "active pump, vco leads");
  endtask : t_vco
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(pas_oe === 1'b0 && act_oe === 1'b0 && lock === 1'b1, "pumps not floating after reset");
    repeat (3) @(negedge clk);
    t_ref;
    t_main;
    t_hold;
    t_pump;
    t_vco;
    end_of_test;
  end
endmodule : spdc_core_test
`default_nettype wire
